//--- can_engine_model.sv
/* behavioural protocol engine and far-side bus traffic for the mailbox block.
   assumes callers enter its tasks just after a rising pclk edge. */
`timescale 1ns/1ps
module can_engine_model #(
   parameter int DATA_W = 32,
   parameter int IDX_W = 8
) (
   // clock
   input wire logic pclk,
   // mailbox state
   input wire logic tx_request,
   input wire logic abort_request,
   // receive events
   output logic rx_frame_end = 1'b0,
   output logic rx_no_error = 1'b0,
   output logic rx_filter_pass = 1'b0,
   output logic [IDX_W-1:0] rx_match_index = '0,
   output logic [DATA_W-1:0] rx_data = '0,
   // transmit events
   output logic tx_attempt_done = 1'b0,
   output logic tx_ok = 1'b0,
   output logic tx_arb_lost = 1'b0,
   output logic tx_bus_error = 1'b0,
   output logic abort_done = 1'b0
);
   task automatic frame(input logic ok, input logic pass, input logic [IDX_W-1:0] idx,
                        input logic [DATA_W-1:0] d, input int lag);
      repeat (lag) @(posedge pclk);
      rx_frame_end <= 1'b1;
      rx_no_error <= ok;
      rx_filter_pass <= pass;
      rx_match_index <= idx;
      rx_data <= d;
      @(posedge pclk);
      // lines released: show the inverse, not stale data
      rx_frame_end <= 1'b0;
      rx_no_error <= !ok;
      rx_filter_pass <= !pass;
      rx_match_index <= ~idx;
      rx_data <= ~d;
   endtask

   // res: 0 success, 1 arbitration lost, 2 bus error
   task automatic attempt(input logic [1:0] res, input int lag);
      repeat (lag) @(posedge pclk);
      while (tx_request !== 1'b1) @(posedge pclk);
      tx_attempt_done <= 1'b1;
      tx_ok <= (res == 2'd0);
      tx_arb_lost <= (res == 2'd1);
      tx_bus_error <= (res == 2'd2);
      @(posedge pclk);
      tx_attempt_done <= 1'b0;
      tx_ok <= (res != 2'd0);
      tx_arb_lost <= (res != 2'd1);
      tx_bus_error <= (res != 2'd2);
   endtask

   task automatic abort(input int lag);
      repeat (lag) @(posedge pclk);
      while (abort_request !== 1'b1) @(posedge pclk);
      abort_done <= 1'b1;
      @(posedge pclk);
      abort_done <= 1'b0;
   endtask
endmodule

//--- can_mailbox_filter_ctrl.sv
/*
 * transmit mailbox control, three-deep receive queue and two filter
 * configuration registers behind an apb slave.
 * assumes the protocol engine runs on pclk and gives one-cycle event pulses.
 */
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module can_mailbox_filter_ctrl #(
   parameter int DATA_W = 32,
   parameter int IDX_W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // controller mode
   input wire logic init_mode,
   // receive side of the protocol engine
   input wire logic rx_frame_end,
   input wire logic rx_no_error,
   input wire logic rx_filter_pass,
   input wire logic [IDX_W-1:0] rx_match_index,
   input wire logic [DATA_W-1:0] rx_data,
   // transmit side of the protocol engine
   input wire logic tx_attempt_done,
   input wire logic tx_ok,
   input wire logic tx_arb_lost,
   input wire logic tx_bus_error,
   input wire logic abort_done,
   output logic tx_request,
   output logic abort_request,
   output logic [DATA_W-1:0] tx_data,
   // filter configuration to the acceptance logic
   output logic [7:0] filter_config_0,
   output logic [7:0] filter_config_1
);
   localparam int QW = DATA_W + IDX_W;

   // bus decode
   logic acc_cycle;
   logic access;
   logic wr_acc;
   logic rd_acc;
   logic sel_ctrl;
   logic sel_txd;
   logic sel_ts;
   logic sel_fmi;
   logic sel_rxd;
   logic sel_rq;
   logic sel_fc0;
   logic sel_fc1;
   logic mapped;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_mux;
   logic [31:0] ctrl_word;
   logic [31:0] txd_word;
   logic [31:0] ts_word;
   logic [31:0] fmi_word;
   logic [31:0] rxd_word;
   logic [31:0] rq_word;
   logic [31:0] fc0_word;
   logic [31:0] fc1_word;

   // transmit mailbox state
   logic transmit_request_bit_reg;
   logic abort_request_bit_reg;
   logic request_completed_flag_reg;
   logic transmit_success_flag_reg;
   logic arbitration_lost_flag_reg;
   logic transmit_error_flag_reg;
   logic transmit_request_bit_next;
   logic abort_request_bit_next;
   logic request_completed_flag_next;
   logic transmit_success_flag_next;
   logic arbitration_lost_flag_next;
   logic transmit_error_flag_next;
   logic [DATA_W-1:0] txd_reg;
   logic mailbox_empty_flag;
   logic wr_ctrl;
   logic wr_txd;
   logic sw_set_send;
   logic sw_set_abort;
   logic sw_clr_done;
   logic clear_status;
   logic hw_empties;
   logic hw_done;
   logic [7:0] mailbox_ctrl_status;
   logic [2:0] transmit_status_reg;

   // receive queue
   logic rx_store;
   logic rx_pop;
   logic [QW-1:0] rx_head;
   logic [1:0] rx_count;
   logic rx_full;
   logic ovr_reg;
   logic ovr_next;
   logic wr_rq;
   logic sw_clr_ovr;
   logic [IDX_W-1:0] filter_match_index;
   logic [DATA_W-1:0] rx_head_data;

   // filter configuration
   logic [7:0] fc0_val;
   logic [7:0] fc1_val;
   logic wr_fc0;
   logic wr_fc1;

   assign acc_cycle = psel && penable;
   assign access = acc_cycle && pready_reg;
   assign wr_acc = access && pwrite;
   assign rd_acc = acc_cycle && !pready_reg && !pwrite;

   assign sel_ctrl = (paddr == can_mbx_pkg::OFF_MAILBOX_CTRL_STATUS);
   assign sel_txd = (paddr == can_mbx_pkg::OFF_TX_DATA);
   assign sel_ts = (paddr == can_mbx_pkg::OFF_TRANSMIT_STATUS);
   assign sel_fmi = (paddr == can_mbx_pkg::OFF_FILTER_MATCH_INDEX);
   assign sel_rxd = (paddr == can_mbx_pkg::OFF_RX_DATA);
   assign sel_rq = (paddr == can_mbx_pkg::OFF_RX_QUEUE_CTRL);
   assign sel_fc0 = (paddr == can_mbx_pkg::OFF_FILTER_CONFIG_0);
   assign sel_fc1 = (paddr == can_mbx_pkg::OFF_FILTER_CONFIG_1);
   assign mapped = sel_ctrl | sel_txd | sel_ts | sel_fmi | sel_rxd | sel_rq | sel_fc0 | sel_fc1;

   // per-register write strobes, only at the completing edge
   assign wr_txd = wr_acc && sel_txd;
   assign wr_rq = wr_acc && sel_rq;
   assign wr_fc0 = wr_acc && sel_fc0;
   assign wr_fc1 = wr_acc && sel_fc1;

   // mailbox is empty whenever no transmission is pending
   assign mailbox_empty_flag = !transmit_request_bit_reg;

   // software strobes on the mailbox control register
   assign wr_ctrl = wr_acc && sel_ctrl;
   assign sw_set_send = wr_ctrl && pwdata[can_mbx_pkg::TRANSMIT_REQUEST_POS]
      && mailbox_empty_flag;
   assign sw_set_abort = wr_ctrl && pwdata[can_mbx_pkg::ABORT_REQUEST_POS]
      && transmit_request_bit_reg;
   assign sw_clr_done = wr_ctrl && pwdata[can_mbx_pkg::REQUEST_COMPLETED_POS];
   // a new request clears the status just as a write-one clear does
   assign clear_status = sw_clr_done || sw_set_send;

   // hardware events from the engine
   assign hw_done = tx_attempt_done && transmit_request_bit_reg;
   assign hw_empties = (hw_done && tx_ok) || (abort_done && transmit_request_bit_reg);

   // next state of the mailbox control bits; hardware events beat software clears
   assign transmit_request_bit_next = hw_empties ? 1'b0 : (transmit_request_bit_reg | sw_set_send);
   assign abort_request_bit_next = hw_empties ? 1'b0 : (abort_request_bit_reg | sw_set_abort);
   assign request_completed_flag_next = hw_empties ? 1'b1
      : (clear_status ? 1'b0 : request_completed_flag_reg);
   assign transmit_success_flag_next = hw_done ? tx_ok
      : (clear_status ? 1'b0 : transmit_success_flag_reg);
   assign arbitration_lost_flag_next = hw_done ? (!tx_ok && tx_arb_lost)
      : (clear_status ? 1'b0 : arbitration_lost_flag_reg);
   assign transmit_error_flag_next = hw_done ? (!tx_ok && tx_bus_error)
      : (clear_status ? 1'b0 : transmit_error_flag_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_request_bit_reg <= can_mbx_pkg::CTRL_STATUS_RESET[can_mbx_pkg::TRANSMIT_REQUEST_POS];
         abort_request_bit_reg <= can_mbx_pkg::CTRL_STATUS_RESET[can_mbx_pkg::ABORT_REQUEST_POS];
         request_completed_flag_reg <= can_mbx_pkg::CTRL_STATUS_RESET[can_mbx_pkg::REQUEST_COMPLETED_POS];
         transmit_success_flag_reg <= can_mbx_pkg::CTRL_STATUS_RESET[can_mbx_pkg::TRANSMIT_SUCCESS_POS];
         arbitration_lost_flag_reg <= can_mbx_pkg::CTRL_STATUS_RESET[can_mbx_pkg::ARBITRATION_LOST_POS];
         transmit_error_flag_reg <= can_mbx_pkg::CTRL_STATUS_RESET[can_mbx_pkg::TRANSMIT_ERROR_POS];
      end else begin
         transmit_request_bit_reg <= transmit_request_bit_next;
         abort_request_bit_reg <= abort_request_bit_next;
         request_completed_flag_reg <= request_completed_flag_next;
         transmit_success_flag_reg <= transmit_success_flag_next;
         arbitration_lost_flag_reg <= arbitration_lost_flag_next;
         transmit_error_flag_reg <= transmit_error_flag_next;
      end
   end

   // transmit payload, locked while a request is pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txd_reg <= '0;
      end else if (wr_txd && mailbox_empty_flag) begin
         txd_reg <= pwdata[DATA_W-1:0];
      end
   end

   assign mailbox_ctrl_status = {2'b00, transmit_error_flag_reg, arbitration_lost_flag_reg,
      transmit_success_flag_reg, request_completed_flag_reg,
      abort_request_bit_reg, transmit_request_bit_reg};
   // per-mailbox copies share the same flops, so they can never disagree
   assign transmit_status_reg = {mailbox_empty_flag, transmit_success_flag_reg,
      request_completed_flag_reg};

   // receive path: only error-free frames that passed filtering are stored
   assign rx_store = rx_frame_end && rx_no_error && rx_filter_pass;
   assign rx_pop = wr_rq && pwdata[can_mbx_pkg::RQ_RELEASE_BIT];

   rx_queue #(
      .DEPTH(can_mbx_pkg::RX_DEPTH),
      .W(QW)
   ) u_rx_queue (
      .pclk(pclk),
      .presetn(presetn),
      .push(rx_store),
      .push_data({rx_match_index, rx_data}),
      .pop(rx_pop),
      .head(rx_head),
      .count(rx_count),
      .full(rx_full)
   );

   assign rx_head_data = rx_head[DATA_W-1:0];
   assign filter_match_index = rx_head[QW-1:DATA_W];

   // frame lost because all three mailboxes are occupied; sticky, set beats clear
   assign sw_clr_ovr = wr_rq && pwdata[can_mbx_pkg::RQ_OVERRUN_BIT];
   assign ovr_next = (rx_store && rx_full) ? 1'b1 : (sw_clr_ovr ? 1'b0 : ovr_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr_reg <= 1'b0;
      end else begin
         ovr_reg <= ovr_next;
      end
   end

   // filter configuration registers
   filter_cfg_reg #(
      .RESET_VAL(can_mbx_pkg::FCFG_RESET)
   ) u_fcfg0 (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_fc0),
      .wdata(pwdata[7:0]),
      .init_mode(init_mode),
      .value(fc0_val)
   );

   filter_cfg_reg #(
      .RESET_VAL(can_mbx_pkg::FCFG_RESET)
   ) u_fcfg1 (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_fc1),
      .wdata(pwdata[7:0]),
      .init_mode(init_mode),
      .value(fc1_val)
   );

   // read words, one per register; the match index and receive data registers have no write path at all
   assign ctrl_word = {24'h000000, mailbox_ctrl_status};
   assign txd_word = 32'(txd_reg);
   assign ts_word = {29'h0, transmit_status_reg};
   assign fmi_word = 32'(filter_match_index);
   assign rxd_word = 32'(rx_head_data);
   assign rq_word = {26'h0, rx_count, 2'b00, ovr_reg, 1'b0};
   assign fc0_word = {24'h000000, fc0_val};
   assign fc1_word = {24'h000000, fc1_val};

   // read data selection
   assign rdata_mux =
      sel_ctrl ? ctrl_word :
      sel_txd ? txd_word :
      sel_ts ? ts_word :
      sel_fmi ? fmi_word :
      sel_rxd ? rxd_word :
      sel_rq ? rq_word :
      sel_fc0 ? fc0_word :
      sel_fc1 ? fc1_word :
      32'h00000000;

   // one wait state per access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= acc_cycle && !pready_reg;
         pslverr_reg <= acc_cycle && !pready_reg && !mapped;
      end
   end

   // read data captured in the wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
      end else if (rd_acc) begin
         prdata_reg <= rdata_mux;
      end
   end

   // engine-facing outputs, all straight from flops
   logic [DATA_W-1:0] tx_data_reg;
   logic [7:0] fc0_out_reg;
   logic [7:0] fc1_out_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_data_reg <= '0;
         fc0_out_reg <= can_mbx_pkg::FCFG_RESET;
         fc1_out_reg <= can_mbx_pkg::FCFG_RESET;
      end else begin
         tx_data_reg <= txd_reg;
         fc0_out_reg <= fc0_val;
         fc1_out_reg <= fc1_val;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign tx_request = transmit_request_bit_reg;
   assign abort_request = abort_request_bit_reg;
   assign tx_data = tx_data_reg;
   assign filter_config_0 = fc0_out_reg;
   assign filter_config_1 = fc1_out_reg;
endmodule

//--- can_mailbox_filter_ctrl_properties.sv
/* port-level assertions for the mailbox and filter configuration block.
   assumes one pclk domain with presetn as its reset. */
`timescale 1ns/1ps
module can_mbx_checker #(
   parameter int DATA_W = 32
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // engine side
   input wire logic init_mode,
   input wire logic tx_attempt_done,
   input wire logic tx_ok,
   input wire logic tx_request,
   input wire logic abort_request,
   input wire logic [DATA_W-1:0] tx_data,
   input wire logic [7:0] filter_config_0,
   input wire logic [7:0] filter_config_1
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_done = psel && penable && pready && pwrite;
   wire [3:0] scales = {filter_config_0[6:5], filter_config_0[2:1]};

   property p_wait_state; psel && !penable ##1 psel && penable |-> !pready ##1 pready; endproperty
   a_wait_state: assert property (p_wait_state) else $error("pready not in second access cycle");
   property p_pready_pulse; pready |=> !pready; endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("pready held too long");
   property p_request_cause; $rose(tx_request) |-> $past(wr_done && paddr == 8'h00 && pwdata[0]); endproperty
   a_request_cause: assert property (p_request_cause) else $error("request rose without write");
   property p_ok_empties; tx_attempt_done && tx_ok && tx_request |=> !tx_request && !abort_request; endproperty
   a_ok_empties: assert property (p_ok_empties) else $error("request kept after success");
   property p_abort_pending; $rose(abort_request) |-> $past(tx_request); endproperty
   a_abort_pending: assert property (p_abort_pending) else $error("abort set while idle");
   property p_reserved_low; (filter_config_0 & 8'h88) == 8'h00 && (filter_config_1 & 8'h88) == 8'h00; endproperty
   a_reserved_low: assert property (p_reserved_low) else $error("reserved filter bit set");
   property p_scale_locked; !$stable(scales) |-> $past(init_mode, 2); endproperty
   a_scale_locked: assert property (p_scale_locked) else $error("scale changed outside init");
   property p_ctrl_top_zero; pready && !pwrite && paddr == 8'h00 |-> prdata[31:6] == 26'h0; endproperty
   a_ctrl_top_zero: assert property (p_ctrl_top_zero) else $error("control upper bits not zero");
   property p_tx_data_frozen; tx_request |=> $stable(tx_data); endproperty
   a_tx_data_frozen: assert property (p_tx_data_frozen) else $error("tx data changed while pending");

   c_success: cover property (tx_attempt_done && tx_ok && tx_request);
   c_abort: cover property ($rose(abort_request));
   c_scale: cover property (!$stable(scales));
endmodule

bind can_mailbox_filter_ctrl can_mbx_checker #(.DATA_W(DATA_W)) chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .init_mode(init_mode), .tx_attempt_done(tx_attempt_done), .tx_ok(tx_ok),
   .tx_request(tx_request), .abort_request(abort_request), .tx_data(tx_data),
   .filter_config_0(filter_config_0), .filter_config_1(filter_config_1));

//--- can_mailbox_filter_ctrl_tb.sv
/* self-checking bench for the mailbox and filter configuration block.
   assumes the engine model answers the transmit and receive sides. */
`timescale 1ns/1ps
module can_mailbox_filter_ctrl_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic init_mode = 1'b0;
   logic [31:0] prdata, tx_data, rx_data;
   logic pready, pslverr, tx_request, abort_request, rx_frame_end, rx_no_error, rx_filter_pass;
   logic tx_attempt_done, tx_ok, tx_arb_lost, tx_bus_error, abort_done;
   logic [7:0] rx_match_index, filter_config_0, filter_config_1;
   logic [32:0] expq[$];
   logic [31:0] seed = 32'h5bda5803;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;

   always #12.5 pclk = ~pclk;

   can_mailbox_filter_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .init_mode, .rx_frame_end, .rx_no_error, .rx_filter_pass, .rx_match_index,
      .rx_data, .tx_attempt_done, .tx_ok, .tx_arb_lost, .tx_bus_error, .abort_done, .tx_request,
      .abort_request, .tx_data, .filter_config_0, .filter_config_1);
   can_engine_model eng_u (.pclk, .tx_request, .abort_request, .rx_frame_end, .rx_no_error,
      .rx_filter_pass, .rx_match_index, .rx_data, .tx_attempt_done, .tx_ok, .tx_arb_lost,
      .tx_bus_error, .abort_done);

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task conclude();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // read results checked against the oldest note
   always @(posedge pclk) begin
      cyc++;
      if (psel && penable && pready === 1'b1 && !pwrite)
         cmp("read", expq.pop_front(), {pslverr, prdata});
      if (cyc > 5000) begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
      expq.push_back({err, e});
      xfer(1'b0, a, 32'h0);
   endtask

   initial begin
      int i;
      logic [31:0] r, d;
      logic [7:0] idx[4];
      logic [31:0] dat[4];
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h00, 32'h0, 1'b0);
      rd(8'h18, 32'h0, 1'b0);
      rd(8'h1c, 32'h0, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      init_mode <= 1'b1;
      wr(8'h18, 32'hffffffff);
      rd(8'h18, 32'h77, 1'b0);
      wr(8'h1c, 32'hff);
      rd(8'h1c, 32'h77, 1'b0);
      cmp("filter_config_1", 33'h77, {25'h0, filter_config_1});
      init_mode <= 1'b0;
      wr(8'h18, 32'h0);
      rd(8'h18, 32'h66, 1'b0);
      cmp("filter_config_0", 33'h66, {25'h0, filter_config_0});
      r = rnd();
      eng_u.frame(1'b0, 1'b1, r[7:0], r, 0);
      eng_u.frame(1'b1, 1'b0, r[15:8], ~r, 3);
      for (i = 0; i < 4; i++) begin
         r = rnd();
         idx[i] = r[7:0];
         dat[i] = rnd();
         eng_u.frame(1'b1, 1'b1, idx[i], dat[i], i * 2 + 1);
      end
      rd(8'h14, 32'h32, 1'b0);
      wr(8'h10, 32'h0);
      wr(8'h0c, 32'h0);
      wr(8'h14, 32'h2);
      for (i = 0; i < 3; i++) begin
         rd(8'h0c, {24'h0, idx[i]}, 1'b0);
         rd(8'h10, dat[i], 1'b0);
         wr(8'h14, 32'h1);
      end
      rd(8'h14, 32'h0, 1'b0);
      d = rnd();
      wr(8'h04, d);
      wr(8'h00, 32'hc1);
      rd(8'h00, 32'h1, 1'b0);
      rd(8'h08, 32'h0, 1'b0);
      wr(8'h04, ~d);
      cmp("tx_data", {1'b0, d}, {1'b0, tx_data});
      eng_u.attempt(2'd1, 2);
      rd(8'h00, 32'h11, 1'b0);
      eng_u.attempt(2'd2, 0);
      rd(8'h00, 32'h21, 1'b0);
      eng_u.attempt(2'd0, 5);
      rd(8'h00, 32'h0c, 1'b0);
      rd(8'h08, 32'h7, 1'b0);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h0c, 1'b0);
      wr(8'h00, 32'h4);
      rd(8'h00, 32'h0, 1'b0);
      rd(8'h08, 32'h4, 1'b0);
      wr(8'h00, 32'h2);
      rd(8'h00, 32'h0, 1'b0);
      wr(8'h00, 32'h1);
      wr(8'h00, 32'h2);
      rd(8'h00, 32'h3, 1'b0);
      eng_u.abort(3);
      rd(8'h00, 32'h4, 1'b0);
      wr(8'h00, 32'h1);
      rd(8'h00, 32'h1, 1'b0);
      eng_u.attempt(2'd0, 0);
      rd(8'h00, 32'h0c, 1'b0);
      repeat (2) @(posedge pclk);
      conclude();
   end
endmodule

//--- can_mbx_pkg.sv
/*
 * constants for the mailbox, receive queue and filter configuration block.
 * assumes byte addresses on a 32-bit apb bus, one register per aligned word.
 */
package can_mbx_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_MAILBOX_CTRL_STATUS = 8'h00;
   localparam logic [7:0] OFF_TX_DATA = 8'h04;
   localparam logic [7:0] OFF_TRANSMIT_STATUS = 8'h08;
   localparam logic [7:0] OFF_FILTER_MATCH_INDEX = 8'h0c;
   localparam logic [7:0] OFF_RX_DATA = 8'h10;
   localparam logic [7:0] OFF_RX_QUEUE_CTRL = 8'h14;
   localparam logic [7:0] OFF_FILTER_CONFIG_0 = 8'h18;
   localparam logic [7:0] OFF_FILTER_CONFIG_1 = 8'h1c;

   // mailbox_ctrl_status fields
   localparam int TRANSMIT_REQUEST_POS = 0;
   localparam int ABORT_REQUEST_POS = 1;
   localparam int REQUEST_COMPLETED_POS = 2;
   localparam int TRANSMIT_SUCCESS_POS = 3;
   localparam int ARBITRATION_LOST_POS = 4;
   localparam int TRANSMIT_ERROR_POS = 5;

   // transmit_status_reg fields
   localparam int TS_COMPLETED_BIT = 0;
   localparam int TS_SUCCESS_BIT = 1;
   localparam int TS_EMPTY_BIT = 2;

   // receive queue control fields
   localparam int RQ_RELEASE_BIT = 0;
   localparam int RQ_OVERRUN_BIT = 1;
   localparam int RQ_COUNT_LSB = 4;

   // filter configuration fields
   localparam int FA_LO_BIT = 0;
   localparam int FS_LO_LSB = 1;
   localparam int FA_HI_BIT = 4;
   localparam int FS_HI_LSB = 5;
   localparam logic [7:0] FCFG_SCALE_MASK = 8'h66;
   localparam logic [7:0] FCFG_ACTIVE_MASK = 8'h11;

   // reset values
   localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
   localparam logic [7:0] FCFG_RESET = 8'h00;

   // receive queue depth
   localparam int RX_DEPTH = 3;
endpackage

//--- filter_cfg_reg.sv
/*
 * one filter configuration register: two filters, each an activation bit
 * and a two-bit scale field.
 * assumes write strobes arrive on the bus clock already decoded.
 */
`timescale 1ns/1ps
module filter_cfg_reg #(
   parameter logic [7:0] RESET_VAL = can_mbx_pkg::FCFG_RESET
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write port
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   input wire logic init_mode,
   // value
   output logic [7:0] value
);
   logic [7:0] cfg_reg;
   logic [7:0] cfg_next;
   logic [7:0] keep_mask;

   // scale bits only change in initialization mode
   assign keep_mask = init_mode ? 8'h00 : can_mbx_pkg::FCFG_SCALE_MASK;
   assign cfg_next = ((wdata & ~keep_mask) | (cfg_reg & keep_mask))
      & (can_mbx_pkg::FCFG_SCALE_MASK | can_mbx_pkg::FCFG_ACTIVE_MASK);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= RESET_VAL;
      end else if (wr_en) begin
         cfg_reg <= cfg_next;
      end
   end

   assign value = cfg_reg;
endmodule

//--- rx_queue.sv
/*
 * receive queue of DEPTH mailboxes, oldest entry presented at the head.
 * assumes push and pop are single-cycle strobes on the same clock.
 */
`timescale 1ns/1ps
module rx_queue #(
   parameter int DEPTH = can_mbx_pkg::RX_DEPTH,
   parameter int W = 40
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // fill side
   input wire logic push,
   input wire logic [W-1:0] push_data,
   // drain side
   input wire logic pop,
   output logic [W-1:0] head,
   output logic [1:0] count,
   output logic full
);
   logic [W-1:0] mem_reg [DEPTH];
   logic [1:0] wr_reg;
   logic [1:0] rd_reg;
   logic [1:0] cnt_reg;
   logic do_push;
   logic do_pop;
   logic [1:0] wr_inc;
   logic [1:0] rd_inc;

   assign full = (cnt_reg == 2'(DEPTH));
   assign do_push = push && !full;
   assign do_pop = pop && (cnt_reg != 2'h0);
   assign wr_inc = (wr_reg == 2'(DEPTH - 1)) ? 2'h0 : wr_reg + 2'h1;
   assign rd_inc = (rd_reg == 2'(DEPTH - 1)) ? 2'h0 : rd_reg + 2'h1;
   assign head = mem_reg[rd_reg];
   assign count = cnt_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_reg <= 2'h0;
         rd_reg <= 2'h0;
         cnt_reg <= 2'h0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else begin
         if (do_push) begin
            mem_reg[wr_reg] <= push_data;
            wr_reg <= wr_inc;
         end
         if (do_pop) begin
            rd_reg <= rd_inc;
         end
         cnt_reg <= cnt_reg + 2'(do_push) - 2'(do_pop);
      end
   end
endmodule
